// *** logic/sac_regs.vh ***
// Purpose: Constants for the converter capture glue logic.
// Assumes: Included by bare name from the design file.
// Notes: Widths of fields are fixed; ratio is a plain default.
`ifndef SAC_REGS_VH
`define SAC_REGS_VH

// Master clock edges per conversion-start period
`define SAC_START_RATIO 8'h08
// Width of the start counter
`define SAC_CNT_W 8
// Converter result width
`define SAC_RES_W 18
// Buffered bus width
`define SAC_BUS_W 16
// Bit positions in the synchroniser vector
`define SAC_S_MCLK_BOARD 0
`define SAC_S_MCLK_LOCAL 1
`define SAC_S_MCLK_SEL 2
`define SAC_S_EXT_SEL 3
`define SAC_S_EXT_START 4
`define SAC_S_CONTROL 5
`define SAC_S_BUSY 6
`define SAC_S_SERIAL 7
`define SAC_S_SLAVE 8
`define SAC_S_BYTE 9
`define SAC_S_NEXT 10
`define SAC_S_SCLK 11
`define SAC_S_SYNC 12
`define SAC_S_CONVERTER_SERIAL_OUT 13
`define SAC_S_RDERR 14
`define SAC_S_DATA 15
`define SAC_SYNC_W 33
// Reset values
`define SAC_BUS_RST 16'h0000
`define SAC_RES_RST 18'h0_0000

`endif

// *** logic/sac_capture.v ***
// Purpose: Glue logic between a SAR converter and a capture board or parallel header.
// Assumes: clk at 10 MHz; every converter and board pin is asynchronous to clk.
// Notes: Master clocks are sampled, not used as clocks, so they must stay well below clk/2.
// Notes on behaviour
// - Start strobe comes from internal generator or external input, chosen by jumper.
// - Master clock is board clock or local oscillator, chosen by host.
// - Internal start rate is a fixed ratio of the master clock.
// - In serial slave mode the converter serial clock equals the master clock.
// - Busy drives an indicator lamp and a monitor output.
// - Capture-board transfers use a 16-bit bus in word or byte mode.
// - 18-bit results are kept whole; word mode reads them as two consecutive 16-bit words, byte mode as three bytes.
// - Bus changes with falling capture busy and rising header busy.
// - Parallel or serial reading, the result appears on the 16-bit bus.
// - Serial data, clock, sync and error go out; data, clock and sync also get buffered copies.
// - Logic makes converter control signals and buffers results in both uses.
// - Control low means stand-alone: logic starts conversions and buffers results.
// - Stand-alone parallel reading holds chip select and read low permanently.
// - Stand-alone with 18-bit converters drives all 18 bits onto the header.
`timescale 1ns/1ps
`include "sac_regs.vh"

module sac_capture (
  input wire clk,
  input wire rst,
  input wire mclk_board,
  input wire mclk_local,
  input wire mclk_sel_local,
  input wire ext_start_sel,
  input wire ext_conversion_start_n,
  input wire control,
  input wire converter_busy,
  input wire serial_mode,
  input wire slave_mode,
  input wire byte_mode,
  input wire next_read,
  input wire converter_sclk_in,
  input wire converter_sync,
  input wire converter_serial_out,
  input wire read_overrun_flag,
  input wire [17:0] converter_data,
  output reg conversion_start_n,
  output reg converter_cs_n,
  output reg converter_rd_n,
  output reg converter_sclk,
  output reg busy_led,
  output reg busy_monitor,
  output reg [15:0] buffered_result_bus,
  output reg [17:0] header_result,
  output reg busy_to_capture_connector,
  output reg busy_to_parallel_header,
  output reg serial_data_tp,
  output reg serial_clock_tp,
  output reg serial_sync_tp,
  output reg read_overrun_tp,
  output reg serial_clock_buf,
  output reg serial_sync_buf,
  output reg serial_data_buf
);

  wire [`SAC_SYNC_W-1:0] async_in;
  reg [`SAC_SYNC_W-1:0] sync_a;
  reg [`SAC_SYNC_W-1:0] sync_b;
  reg mclk_d;
  reg busy_d;
  reg sclk_d;
  reg sync_d;
  reg next_d;
  reg [`SAC_CNT_W-1:0] start_cnt;
  reg [`SAC_RES_W-1:0] shift_reg;
  reg [`SAC_RES_W-1:0] result;
  reg [1:0] read_idx;
  reg [15:0] next_bus;
  wire mclk_s;
  wire mclk_rise;
  wire busy_s;
  wire busy_rise;
  wire busy_fall;
  wire sclk_rise;
  wire sync_fall;
  wire next_rise;
  wire capture_mode;
  wire load_par;
  wire load_ser;
  wire load;
  wire shift_en;
  wire [`SAC_RES_W-1:0] new_result;

  assign async_in = {converter_data, read_overrun_flag, converter_serial_out, converter_sync,
                     converter_sclk_in, next_read, byte_mode, slave_mode, serial_mode,
                     converter_busy, control, ext_conversion_start_n, ext_start_sel,
                     mclk_sel_local, mclk_local, mclk_board};

  // Two-stage synchroniser; only sync_b is read by logic
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_a <= {`SAC_SYNC_W{1'b0}};
      sync_b <= {`SAC_SYNC_W{1'b0}};
    end else begin
      sync_a <= async_in;
      sync_b <= sync_a;
    end
  end

  // Master clock chosen by host select after synchronising both candidates
  assign mclk_s = sync_b[`SAC_S_MCLK_SEL] ? sync_b[`SAC_S_MCLK_LOCAL] :
                  sync_b[`SAC_S_MCLK_BOARD];
  assign busy_s = sync_b[`SAC_S_BUSY];
  assign capture_mode = sync_b[`SAC_S_CONTROL];

  // Delayed copies for edge detection
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mclk_d <= 1'b0;
      busy_d <= 1'b0;
      sclk_d <= 1'b0;
      sync_d <= 1'b0;
      next_d <= 1'b0;
    end else begin
      mclk_d <= mclk_s;
      busy_d <= busy_s;
      sclk_d <= sync_b[`SAC_S_SCLK];
      sync_d <= sync_b[`SAC_S_SYNC];
      next_d <= sync_b[`SAC_S_NEXT];
    end
  end

  assign mclk_rise = mclk_s & ~mclk_d;
  assign busy_rise = busy_s & ~busy_d;
  assign busy_fall = ~busy_s & busy_d;
  assign sclk_rise = sync_b[`SAC_S_SCLK] & ~sclk_d;
  assign sync_fall = ~sync_b[`SAC_S_SYNC] & sync_d;
  assign next_rise = sync_b[`SAC_S_NEXT] & ~next_d;

  // Start generator; counting continues with the external source so a switch back is clean
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      start_cnt <= {`SAC_CNT_W{1'b0}};
      conversion_start_n <= 1'b1;
    end else begin
      conversion_start_n <= 1'b1;
      if (mclk_rise) begin
        if (start_cnt == `SAC_START_RATIO - 8'h01) begin
          start_cnt <= {`SAC_CNT_W{1'b0}};
          conversion_start_n <= sync_b[`SAC_S_EXT_SEL];
        end else begin
          start_cnt <= start_cnt + 8'h01;
        end
      end
      if (sync_b[`SAC_S_EXT_SEL]) begin
        conversion_start_n <= sync_b[`SAC_S_EXT_START];
      end
    end
  end

  // Converter control lines and serial clock in slave mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_cs_n <= 1'b0;
      converter_rd_n <= 1'b0;
      converter_sclk <= 1'b0;
    end else begin
      converter_cs_n <= 1'b0;
      converter_rd_n <= 1'b0;
      converter_sclk <= sync_b[`SAC_S_SLAVE] & mclk_s;
    end
  end

  // Serial collection: shift on each clock rise while the frame sync is high
  assign shift_en = sync_b[`SAC_S_SYNC] &
                    (sync_b[`SAC_S_SLAVE] ? mclk_rise : sclk_rise);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg <= `SAC_RES_RST;
    end else if (shift_en) begin
      shift_reg <= {shift_reg[`SAC_RES_W-2:0], sync_b[`SAC_S_CONVERTER_SERIAL_OUT]};
    end
  end

  // A result lands at the end of conversion (parallel) or frame (serial)
  assign load_par = busy_fall & ~sync_b[`SAC_S_SERIAL];
  assign load_ser = sync_fall & sync_b[`SAC_S_SERIAL];
  assign load = load_par | load_ser;
  assign new_result = load_ser ? shift_reg :
                      sync_b[`SAC_S_DATA+`SAC_RES_W-1:`SAC_S_DATA];

  // Word or byte selection for the capture board; low word first, then upper bits, or in byte mode bits 15:8, 17:16, then 7:0
  always @* begin
    next_bus = buffered_result_bus;
    if (load) begin
      next_bus = new_result[15:0];
    end else if (capture_mode && next_rise) begin
      if (sync_b[`SAC_S_BYTE]) begin
        if (read_idx == 2'd0) begin
          next_bus = {8'h00, result[15:8]};
        end else if (read_idx == 2'd1) begin
          next_bus = {14'h0000, result[17:16]};
        end else begin
          next_bus = {8'h00, result[7:0]};
        end
      end else begin
        next_bus = read_idx[0] ? result[15:0] : {14'h0000, result[17:16]};
      end
    end
  end

  // Result holding, bus refresh and both bus strobes
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      result <= `SAC_RES_RST;
      header_result <= `SAC_RES_RST;
      buffered_result_bus <= `SAC_BUS_RST;
      read_idx <= 2'd0;
      busy_to_capture_connector <= 1'b0;
      busy_to_parallel_header <= 1'b0;
    end else begin
      buffered_result_bus <= next_bus;
      if (load) begin
        result <= new_result;
        read_idx <= 2'd0;
        if (!capture_mode) begin
          header_result <= new_result;
        end
      end else if (capture_mode && next_rise) begin
        read_idx <= read_idx + 2'd1;
      end
      // Load strobe edges (capture falling, header rising) coincide with the bus refresh; busy rise moves the strobes alone
      if (load) begin
        busy_to_capture_connector <= 1'b0;
        busy_to_parallel_header <= 1'b1;
      end else if (busy_rise) begin
        busy_to_capture_connector <= 1'b1;
        busy_to_parallel_header <= 1'b0;
      end
    end
  end

  // Busy lamp, monitor and serial test outputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_led <= 1'b0;
      busy_monitor <= 1'b0;
      serial_data_tp <= 1'b0;
      serial_clock_tp <= 1'b0;
      serial_sync_tp <= 1'b0;
      read_overrun_tp <= 1'b0;
      serial_clock_buf <= 1'b0;
      serial_sync_buf <= 1'b0;
      serial_data_buf <= 1'b0;
    end else begin
      busy_led <= busy_s;
      busy_monitor <= busy_s;
      serial_data_tp <= sync_b[`SAC_S_CONVERTER_SERIAL_OUT];
      serial_clock_tp <= sync_b[`SAC_S_SCLK];
      serial_sync_tp <= sync_b[`SAC_S_SYNC];
      read_overrun_tp <= sync_b[`SAC_S_RDERR];
      serial_clock_buf <= serial_clock_tp;
      serial_sync_buf <= serial_sync_tp;
      serial_data_buf <= serial_data_tp;
    end
  end

endmodule // sac_capture

// *** test/sac_properties.sv ***
// Purpose: Assertions on the capture glue outputs.
// Assumes: rst async high; inputs pass a two-stage sampler.
// Notes: Bound into sac_capture below.
`timescale 1ns/1ps
module sac_props (
  input wire clk, rst, ext_start_sel, ext_conversion_start_n, converter_busy,
  input wire slave_mode, serial_mode, converter_serial_out, converter_sync,
  input wire conversion_start_n, converter_cs_n, converter_rd_n, converter_sclk,
  input wire busy_led, busy_monitor, busy_to_capture_connector, busy_to_parallel_header,
  input wire serial_data_tp, serial_sync_buf,
  input wire converter_sclk_in, read_overrun_flag, serial_clock_tp, serial_sync_tp,
  input wire read_overrun_tp, serial_clock_buf, serial_data_buf,
  input wire [17:0] converter_data,
  input wire [15:0] buffered_result_bus
);
  // One clock domain, so clock and reset are given once
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_strobes_low: assert property (!converter_cs_n && !converter_rd_n)
    else $error("cs or rd high");
  a_start_short: assert property ($fell(conversion_start_n) && !ext_start_sel
    |=> conversion_start_n) else $error("start pulse too long");
  a_ext_follow: assert property (ext_start_sel [*5]
    |-> conversion_start_n == $past(ext_conversion_start_n, 3)) else $error("ext start lost");
  a_sclk_idle: assert property (!slave_mode [*5] |-> !converter_sclk)
    else $error("sclk outside slave");
  a_led_lag: assert property (busy_led == $past(converter_busy, 3) && busy_monitor == busy_led)
    else $error("busy lamp wrong");
  a_strobe_pair: assert property ($fell(busy_to_capture_connector)
    |-> $rose(busy_to_parallel_header)) else $error("strobes apart");
  a_busy_mark: assert property ($rose(converter_busy)
    |-> ##[1:4] busy_to_capture_connector && !busy_to_parallel_header) else $error("no busy mark");
  a_bus_load: assert property ($fell(busy_to_capture_connector) && !serial_mode
    |-> buffered_result_bus == converter_data[15:0]) else $error("bus not loaded");
  a_serial_copy: assert property (serial_data_tp == $past(converter_serial_out, 3)
    && serial_sync_buf == $past(converter_sync, 4)) else $error("serial copy wrong");
  a_serial_rest: assert property (serial_clock_tp == $past(converter_sclk_in, 3)
    && serial_sync_tp == $past(converter_sync, 3)
    && read_overrun_tp == $past(read_overrun_flag, 3)
    && serial_clock_buf == $past(converter_sclk_in, 4)
    && serial_data_buf == $past(converter_serial_out, 4)) else $error("serial test copy wrong");
endmodule // sac_props
bind sac_capture sac_props u_props (.*);

// *** test/sac_adc_model.sv ***
// Purpose: Behavioural converter and board master clock.
// Assumes: Start sampled on clk; CONV is the conversion length in clk.
// Notes: Data moves only at start, so it is settled well before busy falls.
`timescale 1ns/1ps
module sac_adc_model #(parameter int CONV = 6) (
  input wire clk, rst, conversion_start_n,
  output logic converter_busy, mclk_board,
  output logic [17:0] converter_data
);
  int cnt;
  // Board clock runs free, phase unrelated to clk
  initial begin
    mclk_board = 1'b0;
    #137;
    forever #400 mclk_board = ~mclk_board;
  end
  // Converter times its own conversion once started
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      converter_busy <= 1'b0;
      converter_data <= 18'h0_0000;
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      converter_busy <= cnt > 1;
    end else if (!conversion_start_n) begin
      converter_busy <= 1'b1;
      cnt <= CONV;
      converter_data <= converter_data + 18'h2_A5C3; // Odd step reaches every bit
    end
  end
endmodule // sac_adc_model

// *** test/tb_sac_capture.sv ***
// Purpose: Self-checking bench for the capture glue.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Ext start held high parks the converter between scenarios.
`timescale 1ns/1ps
module tb_sac_capture;
  logic clk = 0, rst = 1, mclk_local = 0, mclk_sel_local = 0, ext_start_sel = 1;
  logic ext_conversion_start_n = 1, control = 0, serial_mode = 0, slave_mode = 1, byte_mode = 0;
  logic next_read = 0, converter_sclk_in = 0, converter_sync = 0, converter_serial_out = 0;
  logic read_overrun_flag = 0, mclk_board, converter_busy, conversion_start_n, converter_cs_n;
  logic converter_rd_n, converter_sclk, busy_led, busy_monitor, busy_to_capture_connector;
  logic busy_to_parallel_header, serial_data_tp, serial_clock_tp, serial_sync_tp;
  logic read_overrun_tp, serial_clock_buf, serial_sync_buf, serial_data_buf;
  logic [17:0] converter_data, header_result, d;
  logic [15:0] buffered_result_bus;
  int n_errors = 0, cmp_count = 0, cyc = 0;
  always #50 clk = ~clk;
  always #200 mclk_local = ~mclk_local; // Local oscillator stand-in
  sac_capture dut_u (.*);
  sac_adc_model #(.CONV(6)) u_adc (.*);
  task automatic give_verdict;
    $display("compares %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard: the whole run needs about 800 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      give_verdict;
    end
  end
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_low(output int n);
    n = 0;
    tick(1);
    while (conversion_start_n !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  // Cycles until the slave clock is next seen rising; bounded so a stuck clock fails
  task automatic wait_sclk(output int n);
    n = 0;
    while (converter_sclk === 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    while (converter_sclk !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
  endtask
  // Start period and slave clock both scale with the chosen master
  task automatic t_ratio(input logic sel, input int per);
    int n;
    mclk_sel_local = sel;
    tick(80);
    wait_low(n);
    wait_low(n);
    chk(18'(n + 1), 18'(per));
    wait_sclk(n);
    wait_sclk(n);
    chk(18'(n), 18'(per / 8));
  endtask
  // One externally started conversion, then settle past the load
  task automatic conv;
    ext_conversion_start_n = 0;
    tick(1);
    ext_conversion_start_n = 1;
    tick(2);
    chk(18'(conversion_start_n), 18'h0_0000);
    tick(6);
    chk(18'({busy_led, busy_to_capture_connector, busy_to_parallel_header}), 18'h0_0006);
    tick(30);
    d = converter_data;
  endtask
  task automatic t_standalone;
    control = 0;
    conv;
    chk(18'(buffered_result_bus), 18'(d[15:0]));
    chk(header_result, d);
    chk(18'({busy_to_capture_connector, busy_to_parallel_header}), 18'h0_0001);
  endtask
  task automatic t_reads(input logic bm);
    logic [15:0] e[4];
    byte_mode = bm;
    control = 1;
    conv;
    chk(18'(buffered_result_bus), 18'(d[15:0]));
    if (bm)
      e = '{16'(d[15:8]), 16'(d[17:16]), 16'(d[7:0]), 16'(d[7:0])};
    else
      e = '{16'(d[17:16]), d[15:0], 16'(d[17:16]), d[15:0]};
    for (int i = 0; i < 4; i++) begin
      next_read = 1;
      tick(2);
      next_read = 0;
      tick(4);
      chk(18'(buffered_result_bus), 18'(e[i]));
    end
  endtask
  // Converter as serial master; its clock stands still outside the frame
  task automatic t_serial(input logic [17:0] w);
    serial_mode = 1;
    converter_sync = 1;
    read_overrun_flag = 1;
    for (int i = 17; i >= 0; i--) begin
      converter_serial_out = w[i];
      tick(4);
      converter_sclk_in = 1;
      tick(4);
      converter_sclk_in = 0;
    end
    converter_sync = 0;
    converter_serial_out = ~w[0];
    tick(8);
    chk(18'(buffered_result_bus), 18'(w[15:0]));
    chk(18'({serial_clock_tp, serial_sync_tp, serial_data_tp, read_overrun_tp, serial_clock_buf,
             serial_sync_buf, serial_data_buf}),
        18'({2'b00, ~w[0], 1'b1, 2'b00, ~w[0]}));
    serial_mode = 0;
    read_overrun_flag = 0;
  endtask
  // Slave frame: shifting must follow the master clock, the idle converter clock never moves
  task automatic t_slave;
    slave_mode = 1;
    serial_mode = 1;
    converter_serial_out = 1;
    converter_sync = 1;
    tick(80);
    converter_sync = 0;
    tick(8);
    chk(18'(buffered_result_bus), 18'h0_FFFF);
    serial_mode = 0;
    slave_mode = 0;
    converter_serial_out = 0;
  endtask
  initial begin
    tick(10);
    rst = 0;
    tick(5);
    chk(18'({converter_cs_n, converter_rd_n}), 18'h0_0000);
    ext_start_sel = 0;
    t_ratio(0, 64);
    t_ratio(1, 32);
    ext_start_sel = 1;
    slave_mode = 0;
    tick(10);
    t_standalone;
    t_reads(0);
    t_reads(1);
    t_serial(18'h2_9E17);
    t_slave;
    give_verdict;
  end
endmodule // tb_sac_capture
